/* common/pfcrb_pkg.sv */
package pfcrb_pkg;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CODE_ON_OFF = 8'h01;
  localparam logic [7:0] CODE_POWER_POLICY = 8'h02;
  localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CODE_WRITE_LOCK = 8'h10;
  localparam logic [7:0] CODE_RESTORE_DEFAULT = 8'h12;
  localparam logic [7:0] CODE_STORE_USER = 8'h15;
  localparam logic [7:0] CODE_RESTORE_USER = 8'h16;
  localparam logic [7:0] CODE_FEATURE_REPORT = 8'h19;
  localparam logic [7:0] CODE_FORMAT_MODE = 8'h20;
  localparam logic [7:0] CODE_SETPOINT = 8'h21;
  localparam logic [7:0] CODE_LOOP_SCALE = 8'h29;
  localparam logic [7:0] CODE_MONITOR_SCALE = 8'h2a;
  localparam logic [7:0] CODE_PAGE_ERASE = 8'hd4;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ON_OFF_EN_BIT = 7;
  localparam int POLICY_PWRUP_BIT = 4;
  localparam int POLICY_CMD_BIT = 3;
  localparam int POLICY_PIN_BIT = 2;
  localparam int POLICY_POL_BIT = 1;
  localparam int LOCK_ALL_BIT = 7;
  localparam int LOCK_OP_BIT = 6;
  localparam int LOCK_CFG_BIT = 5;
  localparam int EXP_LSB = 11;
  localparam int MANT10_MSB = 9;
  localparam int MANT12_MSB = 11;

  // ---------------------------------------------------------------
  // fixed read values and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] MARGIN_CTRL_FIXED = 2'h0;
  localparam logic [1:0] MARGIN_FAULT_FIXED = 2'h1;
  localparam logic [7:0] FEATURE_REPORT_FIXED = 8'h20;
  localparam logic [2:0] FORMAT_LINEAR = 3'h0;
  localparam logic RST_ON_OFF_EN = 1'b0;
  localparam logic [3:0] RST_POLICY = 4'h0;
  localparam logic [2:0] RST_LOCK = 3'h0;
  localparam logic [2:0] RST_VOUT_EXP = 3'h0;
  localparam logic [11:0] RST_VOUT_MANT = 12'h000;
  localparam logic [4:0] RST_LOOP_EXP = 5'h00;
  localparam logic [9:0] RST_LOOP_MANT = 10'h000;
  localparam logic [2:0] RST_MON_EXP = 3'h0;
  localparam logic [9:0] RST_MON_MANT = 10'h000;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic is_write;
    logic no_data;
    logic [7:0] code;
    logic [15:0] data;
  } pfcrb_cmd_t;

  typedef struct packed {
    logic ack;
    logic [15:0] data;
  } pfcrb_rsp_t;

  typedef struct packed {
    logic [3:0] policy;
    logic [2:0] vout_exp;
    logic [11:0] vout_mant;
    logic [4:0] loop_exp;
    logic [9:0] loop_mant;
    logic [2:0] mon_exp;
    logic [9:0] mon_mant;
  } pfcrb_settings_t;

endpackage : pfcrb_pkg

/* verilog/pfcrb_register_bank.sv */
`timescale 1ns/1ps
// What this block does
// - on/off enable bit 7: 0 turns off at once, 1 turns on
// - on/off bit 6 reads 0, bits 1:0 reserved, margin bits 5:4 fixed 00
// - on/off margin fault response bits 3:2 always read 01
// - policy bit 4: 0 powers up with power, 1 waits for pin and command
// - policy bit 3: 0 ignores on/off command, 1 requires its enable bit
// - policy bit 2: 0 ignores supply pin, 1 requires the pin asserted
// - policy bit 1: supply pin polarity, 0 active low, 1 active high
// - policy bit 0 reads 1; power-down turns output off at once
// - send-byte 0x03 clears every fault bit at the same instant
// - lock bits 7, 6, 5 give three widening sets of writable commands
// - send-byte 0x12 loads factory defaults from eeprom
// - send-byte 0x15 copies operating memory into eeprom page 1
// - send-byte 0x16 loads stored user settings from eeprom
// - feature bit 7 reads 0, no packet error checking; bits 3:0 reserved
// - feature bits 6:5 fixed 01, 400 kHz bus speed
// - feature bit 4 reads 0, no alert pin support
// - format mode bits 7:5 linear, 4:3 reserved, 2:0 writable exponent
// - setpoint 12-bit mantissa in 11:0, bits 15:12 read zero
// - loop scale exponent 15:11, mantissa 9:0, bit 10 reads 0
// - monitor scale exponent 13:11, mantissa 9:0, 15:14 and 10 read 0
module pfcrb_register_bank (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic cmd_valid,
  input pfcrb_pkg::pfcrb_cmd_t cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output pfcrb_pkg::pfcrb_rsp_t rsp,
  input wire logic supply_on_pin,
  input wire logic power_present,
  input wire logic nvm_load_valid,
  input pfcrb_pkg::pfcrb_settings_t nvm_load,
  output logic device_enable,
  output logic fault_clear,
  output logic nvm_restore_default,
  output logic nvm_store_user,
  output logic nvm_restore_user,
  output logic nvm_page_erase,
  output logic [7:0] nvm_page_erase_arg,
  output pfcrb_pkg::pfcrb_settings_t settings
);

  // ---------------------------------------------------------------
  // state of the link domain
  // ---------------------------------------------------------------
  typedef struct packed {
    logic req_tgl;
    pfcrb_pkg::pfcrb_cmd_t req_hold;
    logic busy;
    logic ready;
    logic rsp_s1;
    logic rsp_s2;
    logic rsp_s3;
    logic rsp_valid;
    pfcrb_pkg::pfcrb_rsp_t rsp;
  } pfcrb_link_t;

  // ---------------------------------------------------------------
  // state of the core domain
  // ---------------------------------------------------------------
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic pin_s1;
    logic pin_s2;
    logic pwr_s1;
    logic pwr_s2;
    logic on_off_en;
    logic [2:0] lock;
    pfcrb_pkg::pfcrb_settings_t set;
    logic rsp_tgl;
    pfcrb_pkg::pfcrb_rsp_t rsp;
    logic enable;
    logic fault_clear;
    logic rst_default;
    logic store_user;
    logic rst_user;
    logic page_erase;
    logic [7:0] page_arg;
  } pfcrb_core_t;

  pfcrb_link_t link_r;
  pfcrb_link_t link_nxt;
  pfcrb_core_t core_r;
  pfcrb_core_t core_nxt;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // write permission for a code under the current lock bits
  function automatic logic pfcrb_write_ok(input logic [2:0] lock, input logic [7:0] code);
    logic ok;
    ok = 1'b1;
    if (lock[2])
    begin
      ok = (code == pfcrb_pkg::CODE_WRITE_LOCK);
    end
    else if (lock[1])
    begin
      ok = (code == pfcrb_pkg::CODE_WRITE_LOCK) || (code == pfcrb_pkg::CODE_ON_OFF)
        || (code == pfcrb_pkg::CODE_PAGE_ERASE);
    end
    else if (lock[0])
    begin
      ok = (code == pfcrb_pkg::CODE_WRITE_LOCK) || (code == pfcrb_pkg::CODE_ON_OFF)
        || (code == pfcrb_pkg::CODE_PAGE_ERASE) || (code == pfcrb_pkg::CODE_POWER_POLICY)
        || (code == pfcrb_pkg::CODE_SETPOINT);
    end
    return ok;
  endfunction : pfcrb_write_ok

  // read value of a code; bit 16 set when the code is mapped
  function automatic logic [16:0] pfcrb_read(input pfcrb_core_t s, input logic [7:0] code);
    logic [16:0] v;
    v = 17'h00000;
    case (code)
      pfcrb_pkg::CODE_ON_OFF:
        v = {1'b1, 8'h00, s.on_off_en, 1'b0, pfcrb_pkg::MARGIN_CTRL_FIXED,
             pfcrb_pkg::MARGIN_FAULT_FIXED, 2'h0};
      pfcrb_pkg::CODE_POWER_POLICY:
        v = {1'b1, 8'h00, 3'h0, s.set.policy, 1'b1};
      pfcrb_pkg::CODE_WRITE_LOCK:
        v = {1'b1, 8'h00, s.lock, 5'h00};
      pfcrb_pkg::CODE_FEATURE_REPORT:
        v = {1'b1, 8'h00, pfcrb_pkg::FEATURE_REPORT_FIXED};
      pfcrb_pkg::CODE_FORMAT_MODE:
        v = {1'b1, 8'h00, pfcrb_pkg::FORMAT_LINEAR, 2'h0, s.set.vout_exp};
      pfcrb_pkg::CODE_SETPOINT:
        v = {1'b1, 4'h0, s.set.vout_mant};
      pfcrb_pkg::CODE_LOOP_SCALE:
        v = {1'b1, s.set.loop_exp, 1'b0, s.set.loop_mant};
      pfcrb_pkg::CODE_MONITOR_SCALE:
        v = {1'b1, 2'h0, s.set.mon_exp, 1'b0, s.set.mon_mant};
      default:
        v = 17'h00000;
    endcase
    return v;
  endfunction : pfcrb_read

  // ---------------------------------------------------------------
  // link domain: take a command, hand it over by toggle, return answer
  // ---------------------------------------------------------------

  // next state of the link side
  always_comb
  begin
    link_nxt = link_r;
    link_nxt.rsp_valid = 1'b0;
    link_nxt.rsp_s1 = core_r.rsp_tgl;
    link_nxt.rsp_s2 = link_r.rsp_s1;
    link_nxt.rsp_s3 = link_r.rsp_s2;
    if (cmd_valid && !link_r.busy)
    begin
      link_nxt.req_hold = cmd; // held stable until the answer returns
      link_nxt.req_tgl = !link_r.req_tgl;
      link_nxt.busy = 1'b1;
    end
    if (link_r.rsp_s2 != link_r.rsp_s3)
    begin
      link_nxt.rsp = core_r.rsp; // written with the toggle and stable since then
      link_nxt.rsp_valid = 1'b1;
      link_nxt.busy = 1'b0;
    end
    link_nxt.ready = !link_nxt.busy; // registered copy so the output comes from a flop
  end

  // link side registers
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_r <= '0;
      link_r.ready <= 1'b1;
    end
    else
    begin
      link_r <= link_nxt;
    end
  end

  // ---------------------------------------------------------------
  // core domain: decode, register update, power enable
  // ---------------------------------------------------------------

  // next state of the core side
  always_comb
  begin
    logic [16:0] rd;
    logic pin_active;
    logic cmd_ok;
    logic pin_ok;
    pfcrb_pkg::pfcrb_cmd_t c;
    rd = 17'h00000;
    pin_active = 1'b0;
    cmd_ok = 1'b0;
    pin_ok = 1'b0;
    c = link_r.req_hold;
    core_nxt = core_r;
    core_nxt.req_s1 = link_r.req_tgl;
    core_nxt.req_s2 = core_r.req_s1;
    core_nxt.req_s3 = core_r.req_s2;
    core_nxt.pin_s1 = supply_on_pin;
    core_nxt.pin_s2 = core_r.pin_s1;
    core_nxt.pwr_s1 = power_present;
    core_nxt.pwr_s2 = core_r.pwr_s1;
    core_nxt.fault_clear = 1'b0;
    core_nxt.rst_default = 1'b0;
    core_nxt.store_user = 1'b0;
    core_nxt.rst_user = 1'b0;
    core_nxt.page_erase = 1'b0;

    // settings loaded back from eeprom after a restore
    if (nvm_load_valid)
    begin
      core_nxt.set = nvm_load;
    end

    // one command per toggle edge
    if (core_r.req_s2 != core_r.req_s3)
    begin
      rd = pfcrb_read(core_r, c.code);
      core_nxt.rsp.data = rd[15:0];
      core_nxt.rsp.ack = rd[16];
      if (c.is_write)
      begin
        core_nxt.rsp.data = 16'h0000;
        core_nxt.rsp.ack = 1'b1;
        if (pfcrb_write_ok(core_r.lock, c.code))
        begin
          case (c.code)
            pfcrb_pkg::CODE_ON_OFF:
              core_nxt.on_off_en = c.data[pfcrb_pkg::ON_OFF_EN_BIT];
            pfcrb_pkg::CODE_POWER_POLICY:
              core_nxt.set.policy = c.data[pfcrb_pkg::POLICY_PWRUP_BIT:pfcrb_pkg::POLICY_POL_BIT];
            pfcrb_pkg::CODE_WRITE_LOCK:
              core_nxt.lock = c.data[pfcrb_pkg::LOCK_ALL_BIT:pfcrb_pkg::LOCK_CFG_BIT];
            pfcrb_pkg::CODE_FORMAT_MODE:
              core_nxt.set.vout_exp = c.data[2:0];
            pfcrb_pkg::CODE_SETPOINT:
              core_nxt.set.vout_mant = c.data[pfcrb_pkg::MANT12_MSB:0];
            pfcrb_pkg::CODE_LOOP_SCALE:
            begin
              core_nxt.set.loop_exp = c.data[15:pfcrb_pkg::EXP_LSB];
              core_nxt.set.loop_mant = c.data[pfcrb_pkg::MANT10_MSB:0];
            end
            pfcrb_pkg::CODE_MONITOR_SCALE:
            begin
              core_nxt.set.mon_exp = c.data[13:pfcrb_pkg::EXP_LSB];
              core_nxt.set.mon_mant = c.data[pfcrb_pkg::MANT10_MSB:0];
            end
            pfcrb_pkg::CODE_PAGE_ERASE:
            begin
              core_nxt.page_erase = 1'b1;
              core_nxt.page_arg = c.data[7:0];
            end
            pfcrb_pkg::CODE_CLEAR_FAULTS:
              core_nxt.fault_clear = c.no_data;
            pfcrb_pkg::CODE_RESTORE_DEFAULT:
              core_nxt.rst_default = c.no_data;
            pfcrb_pkg::CODE_STORE_USER:
              core_nxt.store_user = c.no_data;
            pfcrb_pkg::CODE_RESTORE_USER:
              core_nxt.rst_user = c.no_data;
            default:
              core_nxt.rsp.ack = 1'b0;
          endcase
        end
      end
      core_nxt.rsp_tgl = !core_r.rsp_tgl; // answer is ready
    end

    // power-up decision from policy, command and pin
    pin_active = core_r.set.policy[0] ? core_r.pin_s2 : !core_r.pin_s2;
    cmd_ok = !core_r.set.policy[2] || core_r.on_off_en;
    pin_ok = !core_r.set.policy[1] || pin_active;
    if (!core_r.set.policy[3])
    begin
      core_nxt.enable = core_r.pwr_s2;
    end
    else
    begin
      core_nxt.enable = core_r.pwr_s2 && cmd_ok && pin_ok;
    end
  end

  // core side registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_r <= '0;
      core_r.on_off_en <= pfcrb_pkg::RST_ON_OFF_EN;
      core_r.lock <= pfcrb_pkg::RST_LOCK;
      core_r.set <= {pfcrb_pkg::RST_POLICY, pfcrb_pkg::RST_VOUT_EXP, pfcrb_pkg::RST_VOUT_MANT,
                     pfcrb_pkg::RST_LOOP_EXP, pfcrb_pkg::RST_LOOP_MANT, pfcrb_pkg::RST_MON_EXP,
                     pfcrb_pkg::RST_MON_MANT};
    end
    else
    begin
      core_r <= core_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from flip-flops
  // ---------------------------------------------------------------
  assign cmd_ready = link_r.ready;
  assign rsp_valid = link_r.rsp_valid;
  assign rsp = link_r.rsp;
  assign device_enable = core_r.enable;
  assign fault_clear = core_r.fault_clear;
  assign nvm_restore_default = core_r.rst_default;
  assign nvm_store_user = core_r.store_user;
  assign nvm_restore_user = core_r.rst_user;
  assign nvm_page_erase = core_r.page_erase;
  assign nvm_page_erase_arg = core_r.page_arg;
  assign settings = core_r.set;

endmodule : pfcrb_register_bank

/* sim/pfcrb_sva.sv */
`timescale 1ns/1ps
// ----
// register bank checker
// ----
module pfcrb_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic cmd_valid,
  input pfcrb_pkg::pfcrb_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input pfcrb_pkg::pfcrb_rsp_t rsp,
  input wire logic supply_on_pin,
  input wire logic power_present,
  input wire logic device_enable,
  input wire logic fault_clear,
  input wire logic nvm_store_user,
  input pfcrb_pkg::pfcrb_settings_t settings
);
  // a command taken, and a read of one code taken
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_read(logic [7:0] c);
    s_take ##0 (!cmd.is_write && cmd.code == c);
  endsequence
  a_answer_window: assert property (@(posedge link_clk) disable iff (!rst_n) s_take |-> ##[3:5] rsp_valid)
    else $error("answer not within window");
  a_busy_after: assert property (@(posedge link_clk) disable iff (!rst_n) s_take |=> !cmd_ready)
    else $error("ready stayed high after take");
  a_answer_pulse: assert property (@(posedge link_clk) disable iff (!rst_n) rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  a_feature_fixed: assert property (@(posedge link_clk) disable iff (!rst_n)
    s_read(8'h19) |-> ##[3:5] (rsp_valid && rsp.data == 16'h0020)) else $error("feature report wrong");
  a_margin_fixed: assert property (@(posedge link_clk) disable iff (!rst_n)
    s_read(8'h01) |-> ##[3:5] (rsp_valid && rsp.data[6:0] == 7'h04)) else $error("on/off fixed bits wrong");
  a_power_loss: assert property (@(posedge core_clk) disable iff (!rst_n) !power_present [*4] |-> !device_enable)
    else $error("enable with power absent");
  a_always_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!settings.policy[3] && power_present) [*5] |-> device_enable) else $error("no power-up with power");
  a_pin_low_act: assert property (@(posedge core_clk) disable iff (!rst_n)
    (settings.policy == 4'ha && supply_on_pin) [*5] |-> !device_enable) else $error("pin polarity wrong");
  a_clear_pulse: assert property (@(posedge core_clk) disable iff (!rst_n) $rose(fault_clear) |=> $fell(fault_clear))
    else $error("fault clear not one cycle");
  a_store_pulse: assert property (@(posedge core_clk) disable iff (!rst_n) nvm_store_user |=> !nvm_store_user)
    else $error("store not one cycle");
endmodule : pfcrb_sva

/* sim/pfcrb_host.sv */
`timescale 1ns/1ps
// ----
// host side of the command link
// ----
module pfcrb_host (
  input wire logic link_clk,
  output logic cmd_valid,
  output pfcrb_pkg::pfcrb_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input pfcrb_pkg::pfcrb_rsp_t rsp
);
  // idle link at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // one transaction: hold until taken, release, wait for the answer
  task automatic xfer(input logic w, input logic nd, input logic [7:0] c, input logic [15:0] d,
    output pfcrb_pkg::pfcrb_rsp_t r);
    int n;
    @(negedge link_clk);
    cmd_valid = 1'b1;
    cmd = {w, nd, c, d};
    n = 0;
    // ready is a settled level here, so the next rising edge takes the request
    while (cmd_ready !== 1'b1 && n < 16)
    begin
      @(negedge link_clk);
      n++;
    end
    @(posedge link_clk);
    @(negedge link_clk);
    cmd_valid = 1'b0;
    cmd = ~cmd; // released lines show no stale value
    n = 0;
    // answer pulse stands a whole link cycle, look at it mid-cycle
    do @(negedge link_clk); while (rsp_valid !== 1'b1 && n++ < 16);
    r = rsp;
  endtask : xfer
endmodule : pfcrb_host

/* sim/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
bind pfcrb_register_bank pfcrb_sva pfcrb_sva_inst (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
  .supply_on_pin(supply_on_pin), .power_present(power_present), .device_enable(device_enable),
  .fault_clear(fault_clear), .nvm_store_user(nvm_store_user), .settings(settings));
// ----
// register bank bench
// ----
module tb_top;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n;
  logic supply_on_pin = 1'b0;
  logic power_present = 1'b0;
  logic cmd_valid, cmd_ready, rsp_valid, device_enable;
  logic [4:0] pulse;
  logic [7:0] erase_arg;
  logic [7:0] arg_seen = 8'h00;
  pfcrb_pkg::pfcrb_cmd_t cmd;
  pfcrb_pkg::pfcrb_rsp_t rsp;
  pfcrb_pkg::pfcrb_settings_t settings;
  pfcrb_pkg::pfcrb_rsp_t rsp_hold;
  int n_mismatch, n_compared, seed, m_en, m_pol, m_lock, m_vexp, m_vmant, m_loop, m_mon, m_arg;
  int n_pulse[5] = '{default: 0};
  int e_pulse[5] = '{default: 0};
  int codes[9] = '{8'h01, 8'h02, 8'h10, 8'h19, 8'h20, 8'h21, 8'h29, 8'h2a, 8'h55};
  int sbc[4] = '{8'h03, 8'h12, 8'h15, 8'h16};
  int locks[5] = '{8'h80, 8'h40, 8'h20, 8'he0, 8'h00};
  int pols[4] = '{8'h00, 8'h14, 8'h16, 8'h1e};
  // core clock, and a link clock of unrelated phase
  always #2.5 core_clk = ~core_clk;
  initial
  begin
    #1.7;
    forever #62.5 link_clk = ~link_clk;
  end
  pfcrb_register_bank pfcrb_register_bank_inst (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .supply_on_pin(supply_on_pin), .power_present(power_present), .nvm_load_valid(1'b0), .nvm_load('0),
    .device_enable(device_enable), .fault_clear(pulse[0]), .nvm_restore_default(pulse[1]),
    .nvm_store_user(pulse[2]), .nvm_restore_user(pulse[3]), .nvm_page_erase(pulse[4]),
    .nvm_page_erase_arg(erase_arg), .settings(settings));
  pfcrb_host pfcrb_host_inst (.link_clk(link_clk), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp(rsp));
  // count pulses and catch the erase argument, away from the launching edge
  always @(negedge core_clk)
  begin
    foreach (n_pulse[k]) n_pulse[k] += (pulse[k] === 1'b1);
    if (pulse[4] === 1'b1) arg_seen <= erase_arg;
  end
  // model: which codes the lock level lets through
  function automatic bit ok_code(int c);
    if (c == 8'h10) return 1'b1;
    if (m_lock[2] || (m_lock[1] && c != 8'h01 && c != 8'hd4)) return 1'b0;
    return !(m_lock[0] && !(c inside {8'h01, 8'hd4, 8'h02, 8'h21}));
  endfunction : ok_code
  // model: read value of a code, -1 where unmapped
  function automatic int exp_rd(int c);
    case (c)
      8'h01: return (m_en << 7) | 8'h04;
      8'h02: return (m_pol << 1) | 1;
      8'h10: return m_lock << 5;
      8'h19: return 8'h20;
      8'h20: return m_vexp;
      8'h21: return m_vmant;
      8'h29: return m_loop;
      8'h2a: return m_mon;
      default: return -1;
    endcase
  endfunction : exp_rd
  // model: enable from policy, command and pins
  function automatic logic exp_en();
    logic act;
    act = m_pol[0] ? supply_on_pin : !supply_on_pin;
    return power_present && (!m_pol[3] || ((!m_pol[2] || m_en[0]) && (!m_pol[1] || act)));
  endfunction : exp_en
  task automatic rd_chk(input int c);
    pfcrb_pkg::pfcrb_rsp_t r;
    int e;
    e = exp_rd(c);
    pfcrb_host_inst.xfer(1'b0, 1'b0, c[7:0], 16'h0000, r);
    `CHK(r.ack, e >= 0)
    `CHK(r.data, (e < 0) ? 16'h0000 : e[15:0])
  endtask : rd_chk
  task automatic wr(input int c, input int d);
    pfcrb_pkg::pfcrb_rsp_t r;
    pfcrb_host_inst.xfer(1'b1, 1'b0, c[7:0], d[15:0], r);
    if (ok_code(c))
    begin
      e_pulse[4] += (c == 8'hd4);
      case (c)
        8'h01: m_en = d[7];
        8'h02: m_pol = d[4:1];
        8'h10: m_lock = d[7:5];
        8'h20: m_vexp = d[2:0];
        8'h21: m_vmant = d[11:0];
        8'h29: m_loop = d & 16'hfbff;
        8'h2a: m_mon = d & 16'h3bff;
        8'hd4: m_arg = d[7:0];
        default: ;
      endcase
    end
  endtask : wr
  task automatic wr_all();
    foreach (codes[i]) if (codes[i] != 8'h10) wr(codes[i], $urandom);
    wr(8'hd4, $urandom);
  endtask : wr_all
  task automatic chk_state();
    repeat (8) @(negedge core_clk);
    `CHK(settings, {m_pol[3:0], m_vexp[2:0], m_vmant[11:0], m_loop[15:11], m_loop[9:0], m_mon[13:11], m_mon[9:0]})
    `CHK(device_enable, exp_en())
    `CHK(arg_seen, m_arg[7:0])
    foreach (n_pulse[k]) `CHK(n_pulse[k], e_pulse[k])
  endtask : chk_state
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  // main sequence: reset values, enable cases, random contents, lock levels
  initial
  begin
    rst_n = 1'b0;
    seed = $urandom(96);
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    foreach (codes[i]) rd_chk(codes[i]);
    @(negedge core_clk);
    supply_on_pin = 1'b1;
    power_present = 1'b1;
    foreach (pols[i])
    begin
      wr(8'h02, pols[i]);
      wr(8'h01, i << 7);
      chk_state();
    end
    repeat (8)
    begin
      wr_all();
      @(negedge core_clk);
      supply_on_pin = 1'($urandom);
      power_present = 1'($urandom);
      foreach (codes[i]) rd_chk(codes[i]);
      chk_state();
    end
    foreach (locks[j])
    begin
      wr(8'h10, locks[j]);
      wr_all();
      foreach (sbc[k])
      begin
        wr(sbc[k], 0);
        pfcrb_host_inst.xfer(1'b1, 1'b1, sbc[k][7:0], 16'h0000, rsp_hold);
        e_pulse[k] += ok_code(sbc[k]);
      end
      foreach (codes[i]) rd_chk(codes[i]);
      chk_state();
    end
    give_verdict();
  end
  // watchdog against a hung link
  initial
  begin
    #450000;
    n_mismatch++;
    give_verdict();
  end
endmodule : tb_top
